// [core/irrx_pkg.sv]
/*
  Constants for the IR receive enable and buffer block.
  Assumes a 32-bit register port with byte addresses.
*/
package irrx_pkg;
  localparam logic [7:0]  IRRX_OFF_UNIT_EN   = 8'h00;
  localparam logic [7:0]  IRRX_OFF_RX_EN     = 8'h04;
  localparam logic [7:0]  IRRX_OFF_BUF_LOW   = 8'h08;
  localparam logic [7:0]  IRRX_OFF_BUF_MID   = 8'h0c;
  localparam logic [7:0]  IRRX_OFF_BUF_HIGH  = 8'h10;
  localparam logic [7:0]  IRRX_OFF_CTRL1     = 8'h14;
  localparam logic [7:0]  IRRX_OFF_CTRL2     = 8'h18;
  localparam logic [7:0]  IRRX_OFF_CTRL3     = 8'h1c;
  localparam logic [7:0]  IRRX_OFF_STATUS    = 8'h24;
  localparam logic [7:0]  IRRX_OFF_CLK_SEL   = 8'h34;
  localparam int          IRRX_EN_BIT        = 0;
  localparam int          IRRX_KEEP1_BIT     = 1;
  localparam int          IRRX_BUF_BITS      = 72;
  localparam int          IRRX_CNT_W         = 7;
  localparam logic [31:0] IRRX_CTRL1_RST     = 32'h0000_0000;
  localparam logic [31:0] IRRX_CTRL2_RST     = 32'h0000_ffff;
  localparam logic [31:0] IRRX_CTRL3_RST     = 32'h0000_0000;
  localparam int          IRRX_DATA_MAX_POS  = 0;
  localparam int          IRRX_DATA_MAX_W    = 8;
  localparam int          IRRX_STAT_CNT_POS  = 0;
  localparam int          IRRX_STAT_DONE_POS = 8;
endpackage

// [core/irrx_sync.sv]
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module irrx_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } irrx_sync_t;

  irrx_sync_t st;
  irrx_sync_t next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule

// [core/irrx_core.sv]
/*
  Enable, receive enable and receive buffer of the IR signal receiver.
  Assumes a simple register port and a demodulated IR level, a 32.768 kHz
  clock and a timer output, all asynchronous to sys_clk.
*/
// Function
// - Unit enable bit 0: 0 off, 1 on; set it first.
// - Unit disabled stops every receiver clock except the enable register.
// - Disabling the unit keeps every written register value.
// - Receive enable bit 0 blocks (0) or allows (1) reception.
// - Buffer word low shows received bits 31 to 0.
// - Buffer word mid shows received bits 63 to 32.
// - Buffer word high shows bits 71 to 64 low byte, zero above.
// - Bits shift in MSB first; newest bit lands at bit 0.
// - Sampling clock selectable between 32.768 kHz clock and timer output.
// - One frame ends after 72 one bits (rising edges); zero bits shift in but are not counted.
`timescale 1ns/1ps
module irrx_core
  import irrx_pkg::*;
#(
  parameter int BUF_BITS = IRRX_BUF_BITS
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Sampling sources and IR input
  input  wire logic        slow_clk_in,
  input  wire logic        timer_out_in,
  input  wire logic        ir_in,
  // Status
  output logic             unit_on,
  output logic             rx_active
);
  initial begin
    if (BUF_BITS != IRRX_BUF_BITS) begin
      $error("irrx_core: buffer must hold exactly 72 bits");
    end
    // Status packs the count below the done flag at bit 8
    if ($clog2(BUF_BITS + 1) > IRRX_CNT_W) begin
      $error("irrx_core: bit counter too narrow");
    end
  end

  typedef struct packed {
    logic        unit_en;
    logic        keep1;
    logic        rx_en;
    logic [31:0] ctrl1;
    logic [31:0] ctrl2;
    logic [31:0] ctrl3;
    logic        clk_sel;
    logic [71:0] buffer;
    logic [6:0]  bit_cnt;
    logic        done;
    logic        slow_d;
    logic        ir_d;
    logic [31:0] rdata;
    logic        unit_on;
    logic        rx_active;
  } irrx_state_t;

  irrx_state_t st;
  irrx_state_t next_st;

  logic slow_s;
  logic timer_s;
  logic ir_s;
  logic gate;
  logic samp_lvl;
  logic samp_tick;
  logic bit_tick;
  logic wr_unit;
  logic wr_other;

  irrx_sync u_sync_slow (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (slow_clk_in),
    .sync_out (slow_s)
  );
  irrx_sync u_sync_timer (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (timer_out_in),
    .sync_out (timer_s)
  );
  irrx_sync u_sync_ir (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (ir_in),
    .sync_out (ir_s)
  );

  // Clock gating modelled as an enable so one clock drives everything
  assign gate      = st.unit_en;
  assign samp_lvl  = st.clk_sel ? timer_s : slow_s;
  assign samp_tick = gate && samp_lvl && !st.slow_d;
  // A counted one bit is taken on a sampled rising edge of the IR level
  assign bit_tick  = samp_tick && st.rx_en && !st.done && ir_s && !st.ir_d;
  assign wr_unit   = reg_wr && reg_addr == IRRX_OFF_UNIT_EN;
  assign wr_other  = reg_wr && gate;

  always_comb begin
    next_st = st;
    // Enable register always reachable, even when unit is off
    if (wr_unit) begin
      next_st.unit_en = reg_wdata[IRRX_EN_BIT];
      next_st.keep1   = reg_wdata[IRRX_KEEP1_BIT];
    end
    // Other registers hold their values while the unit is off
    if (wr_other) begin
      unique case (reg_addr)
        IRRX_OFF_RX_EN:   next_st.rx_en   = reg_wdata[IRRX_EN_BIT];
        IRRX_OFF_CTRL1:   next_st.ctrl1   = reg_wdata;
        IRRX_OFF_CTRL2:   next_st.ctrl2   = reg_wdata;
        IRRX_OFF_CTRL3:   next_st.ctrl3   = reg_wdata;
        IRRX_OFF_CLK_SEL: next_st.clk_sel = reg_wdata[0];
        // Read-only words and unmapped offsets land here and are dropped
        default: begin
        end
      endcase
      // Re-arming reception starts a fresh frame
      if (reg_addr == IRRX_OFF_RX_EN && reg_wdata[IRRX_EN_BIT] && !st.rx_en) begin
        next_st.bit_cnt = '0;
        next_st.done    = 1'b0;
      end
    end
    // Edge memory freezes with the unit, so a sample level that rose while off gives a sample edge on re-enabling
    if (gate) begin
      next_st.slow_d = samp_lvl;
      if (samp_tick) begin
        next_st.ir_d = ir_s;
      end
    end
    if (bit_tick) begin
      next_st.buffer  = {st.buffer[70:0], 1'b1};
      next_st.bit_cnt = st.bit_cnt + 7'h01;
      if (st.bit_cnt == 7'(IRRX_BUF_BITS - 1)) begin
        next_st.done = 1'b1;
      end
    end else if (samp_tick && st.rx_en && !st.done && !ir_s && st.ir_d) begin
      next_st.buffer  = {st.buffer[70:0], 1'b0};
    end
    // Read data stands one cycle and then drops to zero, so no stale word lingers
    next_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        IRRX_OFF_UNIT_EN:  next_st.rdata = {30'h0, st.keep1, st.unit_en};
        IRRX_OFF_RX_EN:    next_st.rdata = {31'h0, st.rx_en};
        IRRX_OFF_BUF_LOW:  next_st.rdata = st.buffer[31:0];
        IRRX_OFF_BUF_MID:  next_st.rdata = st.buffer[63:32];
        IRRX_OFF_BUF_HIGH: next_st.rdata = {24'h0, st.buffer[71:64]};
        IRRX_OFF_CTRL1:    next_st.rdata = st.ctrl1;
        IRRX_OFF_CTRL2:    next_st.rdata = st.ctrl2;
        IRRX_OFF_CTRL3:    next_st.rdata = st.ctrl3;
        IRRX_OFF_STATUS:   next_st.rdata = {23'h0, st.done, 1'b0, st.bit_cnt};
        IRRX_OFF_CLK_SEL:  next_st.rdata = {31'h0, st.clk_sel};
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end
    next_st.unit_on   = next_st.unit_en;
    next_st.rx_active = next_st.unit_en && next_st.rx_en && !next_st.done;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= '0;
      st.ctrl1 <= IRRX_CTRL1_RST;
      st.ctrl2 <= IRRX_CTRL2_RST;
      st.ctrl3 <= IRRX_CTRL3_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign unit_on   = st.unit_on;
  assign rx_active = st.rx_active;

  // Assertions
  unit_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_unit |=> unit_on == $past(reg_wdata[0]))
    else $error("unit enable did not follow write");
  gated_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !st.unit_en |=> st.buffer == $past(st.buffer))
    else $error("buffer moved while unit off");
  keep_ctrl_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!st.unit_en && reg_wr && reg_addr == IRRX_OFF_CTRL1) |=> st.ctrl1 == $past(st.ctrl1))
    else $error("control changed while unit off");
  rx_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !st.rx_en |=> st.bit_cnt == $past(st.bit_cnt) || st.bit_cnt == 7'h00)
    else $error("bit counted while reception off");
  read_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_BUF_LOW) |=> reg_rdata == $past(st.buffer[31:0]))
    else $error("low buffer word wrong");
  read_mid_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_BUF_MID) |=> reg_rdata == $past(st.buffer[63:32]))
    else $error("mid buffer word wrong");
  read_high_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_BUF_HIGH) |=> reg_rdata[31:8] == 24'h0)
    else $error("high buffer word upper bits not zero");
  shift_msb_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    bit_tick |=> st.buffer[0] && st.buffer[71:1] == $past(st.buffer[70:0]))
    else $error("buffer did not shift MSB first");
  frame_stop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st.done |-> st.bit_cnt == 7'(IRRX_BUF_BITS))
    else $error("frame ended at wrong count");
  en_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_UNIT_EN) |=> reg_rdata[31:2] == 30'h0)
    else $error("unit enable reserved bits not zero");
  sel_use_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st.unit_en && st.clk_sel) |=> st.slow_d == $past(timer_s))
    else $error("timer source not used");

  // Enable register bits 0 and 1 and the registered enable copy
  unit_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_UNIT_EN)
    |=> reg_rdata[IRRX_EN_BIT] == $past(st.unit_en))
    else $error("unit enable read wrong");
  unit_out_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    unit_on == st.unit_en)
    else $error("unit on output differs from enable");
  keep_bit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_unit
    |=> st.keep1 == $past(reg_wdata[IRRX_KEEP1_BIT]))
    else $error("bit 1 of unit enable not stored");
  keep_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_UNIT_EN)
    |=> reg_rdata[IRRX_KEEP1_BIT] == $past(st.keep1))
    else $error("bit 1 of unit enable read wrong");

  // Frozen while the unit is off
  off_rx_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!st.unit_en && reg_wr && reg_addr == IRRX_OFF_RX_EN)
    |=> st.rx_en == $past(st.rx_en))
    else $error("receive enable changed while unit off");
  off_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !st.unit_en |=> st.bit_cnt == $past(st.bit_cnt))
    else $error("bit count moved while unit off");
  keep_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!st.unit_en && reg_wr && reg_addr == IRRX_OFF_CLK_SEL)
    |=> st.clk_sel == $past(st.clk_sel))
    else $error("clock select changed while unit off");
  keep_ctrl23_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!st.unit_en && reg_wr)
    |=> st.ctrl2 == $past(st.ctrl2) && st.ctrl3 == $past(st.ctrl3))
    else $error("control 2 or 3 changed while unit off");

  // Reception gate
  rx_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st.unit_en && reg_wr && reg_addr == IRRX_OFF_RX_EN)
    |=> st.rx_en == $past(reg_wdata[IRRX_EN_BIT]))
    else $error("receive enable did not follow write");
  rx_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !st.rx_en |=> st.buffer == $past(st.buffer))
    else $error("buffer moved while reception off");
  active_out_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_active == (st.unit_en && st.rx_en && !st.done))
    else $error("receive active output wrong");

  // Buffer layout and shift order
  read_byte_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == IRRX_OFF_BUF_HIGH)
    |=> reg_rdata[7:0] == $past(st.buffer[71:64]))
    else $error("high buffer word low byte wrong");
  shift_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (samp_tick && st.rx_en && !st.done && !ir_s && st.ir_d)
    |=> !st.buffer[0] && st.buffer[71:1] == $past(st.buffer[70:0]))
    else $error("zero bit did not shift in at bit 0");

  // Frame limit and sample clock choice
  full_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st.done |=> st.buffer == $past(st.buffer))
    else $error("buffer moved after frame full");
  count_cap_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st.bit_cnt <= 7'(IRRX_BUF_BITS))
    else $error("bit count beyond frame size");
  done_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (bit_tick && st.bit_cnt == 7'(IRRX_BUF_BITS - 1))
    |=> st.done)
    else $error("frame full not flagged");
  rearm_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st.unit_en && reg_wr && reg_addr == IRRX_OFF_RX_EN && reg_wdata[IRRX_EN_BIT] && !st.rx_en)
    |=> st.bit_cnt == 7'h00 && !st.done)
    else $error("re-arming did not start a fresh frame");
  slow_use_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st.unit_en && !st.clk_sel)
    |=> st.slow_d == $past(slow_s))
    else $error("slow clock source not used");

  // Main scenarios
  frame_full_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(st.done));
  bit_in_c:     cover property (@(posedge sys_clk) disable iff (!arst_n) bit_tick);
  off_write_c:  cover property (@(posedge sys_clk) disable iff (!arst_n) !st.unit_en && wr_unit);
  timer_bit_c:  cover property (@(posedge sys_clk) disable iff (!arst_n) bit_tick && st.clk_sel);
  rearm_c:      cover property (@(posedge sys_clk) disable iff (!arst_n) wr_other && reg_addr == IRRX_OFF_RX_EN && !st.rx_en);
endmodule

// [tb/irrx_ir_src.sv]
/*
  Demodulated IR source with its two sample clocks.
  Assumes one level change of IR per sample clock pulse.
*/
`timescale 1ns/1ps
module irrx_ir_src (
  // Clock
  input  wire logic sys_clk,
  // Which sample clock pulses
  input  wire logic use_timer,
  // Lines to the receiver
  output logic      slow_clk_in,
  output logic      timer_out_in,
  output logic      ir_in
);
  initial begin
    slow_clk_in  = 1'b0;
    timer_out_in = 1'b0;
    ir_in        = 1'b0;
  end

  // Rise is a 1, fall a 0; sample clocks idle low between frames
  task automatic send(input int n);
    repeat (n) begin
      ir_in <= ~ir_in;
      repeat (4) @(posedge sys_clk);
      if (use_timer) begin
        timer_out_in <= 1'b1;
      end else begin
        slow_clk_in <= 1'b1;
      end
      repeat (4) @(posedge sys_clk);
      timer_out_in <= 1'b0;
      slow_clk_in  <= 1'b0;
    end
  endtask
endmodule

// [tb/irrx_core_test.sv]
/*
  Self-checking bench for the IR receive enable and buffer block.
  Assumes the IR source model drives the sample clocks and IR level.
*/
`timescale 1ns/1ps
module irrx_core_test;
  import irrx_pkg::*;
  logic        sys_clk, arst_n, reg_wr, reg_rd, use_timer;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  wire  [31:0] reg_rdata;
  wire         slow_clk_in, timer_out_in, ir_in, unit_on, rx_active;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;

  irrx_ir_src src (.sys_clk(sys_clk), .use_timer(use_timer), .slow_clk_in(slow_clk_in),
                   .timer_out_in(timer_out_in), .ir_in(ir_in));
  irrx_core DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_clk_in(slow_clk_in),
                 .timer_out_in(timer_out_in), .ir_in(ir_in), .unit_on(unit_on), .rx_active(rx_active));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Whole run needs about 1300 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Let the write settle before any caller looks at an output
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask

  task automatic t_reset();
    rd(IRRX_OFF_UNIT_EN, 32'h0000_0000, "unit enable");
    chk("unit on reset", {31'h0, unit_on}, 32'h0000_0000);
    chk("rx reset", {31'h0, rx_active}, 32'h0000_0000);
    rd(IRRX_OFF_RX_EN, 32'h0000_0000, "rx enable");
    rd(IRRX_OFF_BUF_LOW, 32'h0000_0000, "buf low");
    rd(IRRX_OFF_BUF_MID, 32'h0000_0000, "buf mid");
    rd(IRRX_OFF_BUF_HIGH, 32'h0000_0000, "buf high");
    rd(8'h3c, 32'h0000_0000, "unmapped");
    rd(IRRX_OFF_CTRL2, IRRX_CTRL2_RST, "ctrl2");
    @(posedge sys_clk);
    #1 chk("stale rdata", reg_rdata, 32'h0000_0000);
  endtask

  task automatic t_enable();
    wr(IRRX_OFF_UNIT_EN, 32'hffff_ffff);
    rd(IRRX_OFF_UNIT_EN, 32'h0000_0003, "unit enable bits");
    chk("unit on", {31'h0, unit_on}, 32'h0000_0001);
    wr(IRRX_OFF_CTRL1, 32'h4030_2010);
    wr(IRRX_OFF_CTRL2, IRRX_CTRL2_RST);
    wr(IRRX_OFF_CTRL3, 32'h0000_0000);
    chk("rx idle", {31'h0, rx_active}, 32'h0000_0000);
    wr(IRRX_OFF_RX_EN, 32'hffff_ffff);
    rd(IRRX_OFF_RX_EN, 32'h0000_0001, "rx enable bits");
    chk("rx active", {31'h0, rx_active}, 32'h0000_0001);
  endtask

  task automatic t_order();
    src.send(2);
    repeat (6) @(posedge sys_clk);
    rd(IRRX_OFF_BUF_LOW, 32'h0000_0002, "newest at bit 0");
    wr(IRRX_OFF_BUF_LOW, 32'hffff_ffff);
    rd(IRRX_OFF_BUF_LOW, 32'h0000_0002, "buf low ro");
    rd(IRRX_OFF_BUF_MID, 32'h0000_0000, "buf mid short");
  endtask

  task automatic t_frozen();
    wr(IRRX_OFF_UNIT_EN, 32'h0000_0002);
    chk("unit off", {31'h0, unit_on}, 32'h0000_0000);
    chk("rx off", {31'h0, rx_active}, 32'h0000_0000);
    src.send(2);
    wr(IRRX_OFF_RX_EN, 32'h0000_0000);
    wr(IRRX_OFF_CTRL1, 32'h0000_0000);
    wr(IRRX_OFF_UNIT_EN, 32'h0000_0003);
    rd(IRRX_OFF_RX_EN, 32'h0000_0001, "rx kept");
    rd(IRRX_OFF_CTRL1, 32'h4030_2010, "ctrl1 kept");
    rd(IRRX_OFF_BUF_LOW, 32'h0000_0002, "no shift while off");
  endtask

  task automatic t_frame();
    wr(IRRX_OFF_CLK_SEL, 32'h0000_0001);
    use_timer <= 1'b1;
    wr(IRRX_OFF_RX_EN, 32'h0000_0000);
    wr(IRRX_OFF_RX_EN, 32'h0000_0001);
    src.send(142);
    repeat (6) @(posedge sys_clk);
    chk("one bit short", {31'h0, rx_active}, 32'h0000_0001);
    src.send(1);
    repeat (6) @(posedge sys_clk);
    chk("frame full", {31'h0, rx_active}, 32'h0000_0000);
    rd(IRRX_OFF_STATUS, 32'h0000_0148, "status");
    rd(IRRX_OFF_BUF_LOW, 32'h5555_5555, "frame low");
    rd(IRRX_OFF_BUF_MID, 32'h5555_5555, "frame mid");
    rd(IRRX_OFF_BUF_HIGH, 32'h0000_0055, "frame high");
    src.send(2);
    repeat (6) @(posedge sys_clk);
    rd(IRRX_OFF_BUF_LOW, 32'h5555_5555, "held when full");
  endtask

  initial begin
    arst_n    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    use_timer = 1'b0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_enable();
    t_order();
    t_frozen();
    t_frame();
    complete_run();
  end
endmodule
